// ### design/gate_path.v
// Purpose: Gate source selection, polarity, toggle and single-pulse logic
// Assumes: Gate sources are already synchronous; gate state steps on every clk_en cycle
// Notes:   Produces the count-enable level and a single-pulse completion pulse
`timescale 1ns/10ps
`include "gate_timer_defines.vh"

module gate_path (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rst,
   input  wire       clk_en,
   // Sources, already synchronised
   input  wire [3:0] sources,
   // Controls
   input  wire [1:0] gate_source_select,
   input  wire       gate_polarity,
   input  wire       gate_toggle_mode,
   input  wire       gate_single_pulse_mode,
   input  wire       pulse_arm_done,
   // Results
   output wire       gate_value,
   output wire       pulse_done
);

   reg  toggle_ff;
   reg  prev_pol;
   reg  armed_open;
   reg  prev_toggled;
   wire selected;
   wire polarised;
   wire toggled;
   wire rise_pol;

   // ======================================================================
   // Source selection and polarity
   assign selected  = sources[gate_source_select];
   assign polarised = ~(selected ^ gate_polarity);
   assign rise_pol  = polarised & ~prev_pol;

   // ======================================================================
   // Toggle flip-flop, held clear when toggle mode is off
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         toggle_ff <= 1'b0;
         prev_pol  <= 1'b0;
      end else if (clk_en) begin
         prev_pol <= polarised;
         if (!gate_toggle_mode)
            toggle_ff <= 1'b0;
         else if (rise_pol)
            toggle_ff <= ~toggle_ff;
      end
   end

   assign toggled = gate_toggle_mode ? toggle_ff : polarised;

   // ======================================================================
   // Single pulse: open on the next rising gate edge after arming
   // A gate already high when armed waits for its next rising edge
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         armed_open   <= 1'b0;
         prev_toggled <= 1'b0;
      end else if (clk_en) begin
         prev_toggled <= toggled;
         if (!gate_single_pulse_mode || !pulse_arm_done)
            armed_open <= 1'b0;
         else if (toggled && !prev_toggled)
            armed_open <= 1'b1;
      end
   end

   assign gate_value = gate_single_pulse_mode ?
                       (toggled & pulse_arm_done & (armed_open | ~prev_toggled)) :
                       toggled;
   assign pulse_done = gate_single_pulse_mode & pulse_arm_done & armed_open &
                       prev_toggled & ~toggled;

endmodule

// ### design/gate_timer.v
// Purpose: Sixteen-bit timer with overflow flag, special-event reset and gating
// Assumes: Wishbone classic slave; all inputs synchronous except gate sources and clock pins
// Notes:   Answers one cycle after the request; ack drops the next cycle
`timescale 1ns/10ps
`include "gate_timer_defines.vh"

// What this block does
// - Sixteen-bit count counts up from zero to all ones and wraps.
// - Every wrap sets the sticky overflow flag.
// - Overflow interrupt asserts only while its enable bit is set.
// - Compare special-event trigger for this timer clears the count.
// - A count write in the same cycle beats the special-event reset.
// - Special-event clear never sets the overflow flag.
// - Gate enable bit turns gating on; polarity bit picks active level.
// - Gated count advances only while gate level matches polarity.
// - Gate source: pin, period-timer match, comparator one, comparator two.
// - Period-timer match gate is a one-instruction-cycle high pulse.
// - Match gate counts one cycle when high polarity, else all others.
// - Toggle mode passes the gate through an edge-toggled flip-flop.
// - Toggle flip-flop held at zero while toggle mode is off.
// - Arm single pulse after enabling it; counting opens at next gate edge.
// - Trailing gate edge clears arm bit; further gate events ignored.
// - Clearing single-pulse enable also clears the arm bit.
// - Toggle plus single pulse counts exactly one full gate period.
// - Gate level status readable, valid even with gating disabled.
// - In toggle mode status is high while toggled gate counts.
// - Clock source: system clock, quarter rate, or external pin/oscillator.
// - Wide mode: low read latches high byte; low write loads it.
module gate_timer (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        clk_en,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [5:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Gate sources
   input  wire        gate_input_pin,
   input  wire        period_match,
   input  wire        comparator_one,
   input  wire        comparator_two,
   // Clock inputs
   input  wire        external_clock_pin,
   input  wire        crystal_osc_clock,
   // Compare unit
   input  wire        special_event,
   input  wire [3:0]  compare_mode_field,
   input  wire        compare_uses_timer,
   // Interrupt requests
   output reg         overflow_irq,
   output reg         gate_event_irq
);

   // ======================================================================
   // State
   reg  [7:0]  count_low_byte;
   reg  [7:0]  count_high_byte;
   reg  [7:0]  high_buffer;
   reg  [7:0]  timer_control;
   reg  [4:0]  gate_ctl;
   reg  [1:0]  gate_sel;
   reg  [1:0]  periph_irq_flags;
   reg  [1:0]  periph_irq_enables;
   reg  [1:0]  quarter_cnt;
   reg         ext_prev;
   reg  [7:0]  next_low;
   reg  [7:0]  next_high;
   reg  [31:0] next_rdata;

   wire [3:0]  sync_src;
   wire [1:0]  sync_clk;
   wire        gate_value;
   wire        pulse_done;
   wire        req;
   wire        wr;
   wire        rd;
   wire        timer_on;
   wire        wide_access_mode;
   wire [1:0]  clock_source_select;
   wire        gate_enable;
   wire        tick;
   wire        ext_level;
   wire        count_ok;
   wire        inc;
   wire        wrap;
   wire        sev_clear;
   wire        count_wr;
   wire        wr_low;
   wire        wr_high;
   wire [15:0] count;
   wire [15:0] count_plus;
   wire [7:0]  gate_control_rd;

   // ======================================================================
   // Byte-lane merge used by the timer_control write
   function [7:0] merge_byte;
      input [7:0] old_val;
      input [7:0] new_val;
      input       lane;
      begin
         merge_byte = lane ? new_val : old_val;
      end
   endfunction

   // Address decode used by read and write paths
   function hit;
      input [5:0] adr;
      input [5:0] ofs;
      begin
         hit = (adr[5:2] == ofs[5:2]);
      end
   endfunction

   // ======================================================================
   // Synchronisers for gate sources and the external clock inputs
   sync_two_ff #(.WIDTH(4)) u_sync_gate (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clk_en   (clk_en),
      .async_in ({comparator_two, comparator_one, period_match, gate_input_pin}),
      .sync_out (sync_src)
   );

   sync_two_ff #(.WIDTH(2)) u_sync_clk (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clk_en   (clk_en),
      .async_in ({crystal_osc_clock, external_clock_pin}),
      .sync_out (sync_clk)
   );

   // ======================================================================
   // Gate logic
   gate_path u_gate (
      .clk_sys                (clk_sys),
      .rst                    (rst),
      .clk_en                 (clk_en),
      .sources                (sync_src),
      .gate_source_select     (gate_sel),
      .gate_polarity          (gate_ctl[3]),
      .gate_toggle_mode       (gate_ctl[2]),
      .gate_single_pulse_mode (gate_ctl[1]),
      .pulse_arm_done         (gate_ctl[0]),
      .gate_value             (gate_value),
      .pulse_done             (pulse_done)
   );

   // ======================================================================
   // Control decode
   assign req                 = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr                  = req & wb_we_i & wb_sel_i[0];
   assign rd                  = req & ~wb_we_i;
   assign timer_on            = timer_control[`TC_ON];
   assign wide_access_mode    = timer_control[`TC_WIDE];
   assign clock_source_select = timer_control[`TC_CS_HI:`TC_CS_LO];
   assign gate_enable         = gate_ctl[4];
   assign gate_control_rd     = {gate_ctl, gate_value, gate_sel};
   assign wr_low              = wr & hit(wb_adr_i, `OFS_COUNT_LOW);
   assign wr_high             = wr & hit(wb_adr_i, `OFS_COUNT_HIGH);

   // ======================================================================
   // Clock source selection
   assign ext_level = timer_control[`TC_OSC_EN] ? sync_clk[1] : sync_clk[0];
   assign tick = (clock_source_select == `CS_SYSTEM)   ? 1'b1 :
                 (clock_source_select == `CS_QUARTER)  ? (quarter_cnt == `QUARTER_DIV) :
                 (clock_source_select == `CS_EXTERNAL) ? (ext_level & ~ext_prev) :
                 1'b0;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         quarter_cnt <= 2'b00;
         ext_prev    <= 1'b0;
      end else if (clk_en) begin
         quarter_cnt <= quarter_cnt + 2'b01;
         ext_prev    <= ext_level;
      end
   end

   // ======================================================================
   // Counting
   assign count      = {count_high_byte, count_low_byte};
   assign count_plus = count + 16'h0001;
   assign count_ok   = ~gate_enable | gate_value;
   assign inc        = timer_on & tick & count_ok;
   // A count write or a trigger clear replaces the increment, so no wrap
   assign count_wr   = wr_low | (wr_high & ~wide_access_mode);
   assign wrap       = inc & ~count_wr & ~sev_clear &
                       (count == `COUNT_MAX);
   assign sev_clear  = special_event & compare_uses_timer &
                       (compare_mode_field == `SPECIAL_EVENT_MODE);

   always @* begin
      next_low  = count_low_byte;
      next_high = count_high_byte;
      if (wr_low) begin
         next_low = wb_dat_i[7:0];
         if (wide_access_mode)
            next_high = high_buffer;
      end else if (wr_high && !wide_access_mode) begin
         next_high = wb_dat_i[7:0];
      end else if (sev_clear) begin
         next_low  = `RST_BYTE;
         next_high = `RST_BYTE;
      end else if (inc) begin
         next_low  = count_plus[7:0];
         next_high = count_plus[15:8];
      end
   end

   // ======================================================================
   // Registers
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_low_byte     <= `RST_BYTE;
         count_high_byte    <= `RST_BYTE;
         high_buffer        <= `RST_BYTE;
         timer_control      <= `RST_BYTE;
         gate_ctl           <= 5'b00000;
         periph_irq_flags   <= 2'b00;
         periph_irq_enables <= 2'b00;
      end else if (clk_en) begin
         count_low_byte  <= next_low;
         count_high_byte <= next_high;
         if (rd && wide_access_mode && hit(wb_adr_i, `OFS_COUNT_LOW))
            high_buffer <= count_high_byte;
         else if (wr_high && wide_access_mode)
            high_buffer <= wb_dat_i[7:0];
         if (wr && hit(wb_adr_i, `OFS_TIMER_CONTROL))
            timer_control <= merge_byte(timer_control, wb_dat_i[7:0] & `TC_WMASK,
                                        wb_sel_i[0]);
         if (wr && hit(wb_adr_i, `OFS_GATE_CONTROL)) begin
            gate_ctl[4] <= wb_dat_i[`GC_EN];
            gate_ctl[3] <= wb_dat_i[`GC_POL];
            gate_ctl[2] <= wb_dat_i[`GC_TM];
            gate_ctl[1] <= wb_dat_i[`GC_SPM];
            gate_ctl[0] <= wb_dat_i[`GC_ARM] & wb_dat_i[`GC_SPM];
         end else if (pulse_done) begin
            gate_ctl[0] <= 1'b0;
         end
         if (wr && hit(wb_adr_i, `OFS_IRQ_ENABLES))
            periph_irq_enables <= wb_dat_i[1:0];
         // Hardware set wins over a software clear in the same cycle
         periph_irq_flags[`IRQ_OVF] <= wrap |
            (periph_irq_flags[`IRQ_OVF] &
             ~(wr && hit(wb_adr_i, `OFS_IRQ_FLAGS) && !wb_dat_i[`IRQ_OVF]));
         periph_irq_flags[`IRQ_GATE] <= pulse_done |
            (periph_irq_flags[`IRQ_GATE] &
             ~(wr && hit(wb_adr_i, `OFS_IRQ_FLAGS) && !wb_dat_i[`IRQ_GATE]));
      end
   end

   // ======================================================================
   // Gate source select kept separately (low two bits of gate_control)
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         gate_sel <= 2'b00;
      else if (clk_en && wr && hit(wb_adr_i, `OFS_GATE_CONTROL))
         gate_sel <= wb_dat_i[`GC_SS_HI:`GC_SS_LO];
   end

   // ======================================================================
   // Read mux and acknowledge
   always @* begin
      next_rdata = 32'h0000_0000;
      if (hit(wb_adr_i, `OFS_COUNT_LOW))
         next_rdata[7:0] = count_low_byte;
      else if (hit(wb_adr_i, `OFS_COUNT_HIGH))
         next_rdata[7:0] = wide_access_mode ? high_buffer : count_high_byte;
      else if (hit(wb_adr_i, `OFS_TIMER_CONTROL))
         next_rdata[7:0] = timer_control;
      else if (hit(wb_adr_i, `OFS_GATE_CONTROL))
         next_rdata[7:0] = gate_control_rd;
      else if (hit(wb_adr_i, `OFS_IRQ_FLAGS))
         next_rdata[1:0] = periph_irq_flags;
      else if (hit(wb_adr_i, `OFS_IRQ_ENABLES))
         next_rdata[1:0] = periph_irq_enables;
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wb_ack_o       <= 1'b0;
         wb_dat_o       <= 32'h0000_0000;
         overflow_irq   <= 1'b0;
         gate_event_irq <= 1'b0;
      end else if (clk_en) begin
         wb_ack_o <= req;
         if (rd)
            wb_dat_o <= next_rdata;
         overflow_irq   <= periph_irq_flags[`IRQ_OVF] &
                           periph_irq_enables[`IRQ_OVF];
         gate_event_irq <= periph_irq_flags[`IRQ_GATE] &
                           periph_irq_enables[`IRQ_GATE];
      end
   end

endmodule

// ### design/sync_two_ff.v
// Purpose: Two-flop synchroniser for a group of level inputs
// Assumes: Inputs may be asynchronous to clk_sys
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps

module sync_two_ff #(
   parameter WIDTH = 4
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst,
   input  wire             clk_en,
   // Data
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage_one;

   // ======================================================================
   // Two stages
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage_one <= {WIDTH{1'b0}};
         sync_out  <= {WIDTH{1'b0}};
      end else if (clk_en) begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

// ### inc/gate_timer_defines.vh
// Purpose: Register offsets, field positions and reset values of the gated timer
// Assumes: Wishbone classic slave with 32-bit data, one register per aligned word
// Notes:   Narrow registers sit in the low bits; upper bits read as zero
`ifndef GATE_TIMER_DEFINES_VH
`define GATE_TIMER_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define OFS_COUNT_LOW        6'h00
`define OFS_COUNT_HIGH       6'h04
`define OFS_TIMER_CONTROL    6'h08
`define OFS_GATE_CONTROL     6'h0C
`define OFS_IRQ_FLAGS        6'h10
`define OFS_IRQ_ENABLES      6'h14

// ==========================================================================
// timer_control fields
`define TC_ON                0
`define TC_WIDE              1
`define TC_OSC_EN            3
`define TC_CS_LO             6
`define TC_CS_HI             7
`define TC_WMASK             8'hCB

// ==========================================================================
// gate_control fields
`define GC_SS_LO             0
`define GC_SS_HI             1
`define GC_LEVEL             2
`define GC_ARM               3
`define GC_SPM               4
`define GC_TM                5
`define GC_POL               6
`define GC_EN                7

// ==========================================================================
// Flag and enable bit positions
`define IRQ_OVF              0
`define IRQ_GATE             1

// ==========================================================================
// Encodings and reset values
`define CS_QUARTER           2'b00
`define CS_SYSTEM            2'b01
`define CS_EXTERNAL          2'b10
`define GS_PIN               2'b00
`define GS_PERIOD            2'b01
`define GS_CMP1              2'b10
`define GS_CMP2              2'b11
`define SPECIAL_EVENT_MODE   4'hB
`define RST_BYTE             8'h00
`define RST_COUNT            16'h0000
`define COUNT_MAX            16'hFFFF
`define QUARTER_DIV          2'b11

`endif

// ### testbench/gate_partner.sv
// Purpose: Far side: gate sources, period-timer match pulse, compare trigger
// Assumes: Bench changes requests just after the rising edge
// Notes:   lv bit n enables gate source n; bit 1 lets match pulses out
`timescale 1ns/10ps
module gate_partner (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Bench requests
   input  wire logic [3:0] lv,
   input  wire logic       se_req,
   // Toward the timer
   output logic            gate_input_pin,
   output logic            period_match,
   output logic            comparator_one,
   output logic            comparator_two,
   output logic            special_event,
   output logic [3:0]      compare_mode_field,
   output logic            compare_uses_timer
);
   logic [2:0] phase;
   assign gate_input_pin = lv[0];
   assign comparator_one = lv[2];
   assign comparator_two = lv[3];
   assign special_event = se_req;
   assign compare_mode_field = 4'hB;
   assign compare_uses_timer = 1'b1;
   // One-cycle match pulse every eighth cycle
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase <= 3'h0;
         period_match <= 1'b0;
      end else begin
         phase <= phase + 3'h1;
         period_match <= lv[1] && phase == 3'h7;
      end
   end
endmodule

// ### testbench/gate_timer_props.sv
// Purpose: Port-level checks of the gated timer
// Assumes: One clock domain, reset asynchronous and active high
// Notes:   Bound to the design from tb_top
`timescale 1ns/10ps
module gate_timer_props (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        clk_en,
   // Wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Interrupts
   input wire logic        overflow_irq,
   input wire logic        gate_event_irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ==========================================================
   // Bus handshake
   ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
      else $error("request not answered next cycle");
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   read_high_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("read data above bit 7 not zero");
   unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) >= 6'h18
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   // ==========================================================
   // Interrupt masking and reset
   ovf_mask_a: assert property (wb_ack_o && $past(wb_we_i && wb_sel_i[0] &&
      wb_adr_i[5:2] == 4'h5 && !wb_dat_i[0]) |-> ##[1:2] !overflow_irq)
      else $error("overflow irq not masked");
   gate_mask_a: assert property (wb_ack_o && $past(wb_we_i && wb_sel_i[0] &&
      wb_adr_i[5:2] == 4'h5 && !wb_dat_i[1]) |-> ##[1:2] !gate_event_irq)
      else $error("gate irq not masked");
   reset_quiet_a: assert property ($past(rst) |-> !wb_ack_o && !overflow_irq && !gate_event_irq)
      else $error("outputs active after reset");
   cover property (wb_ack_o && $past(wb_we_i));
   cover property ($rose(overflow_irq));
   cover property ($rose(gate_event_irq));
endmodule

// ### testbench/tb_top.sv
// Purpose: Self-checking bench of the gated timer
// Assumes: Count frozen by an inactive gate, so reads are exact
// Notes:   Tests run in order and build on the previous setup
`timescale 1ns/10ps
module tb_top;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [5:0]  wb_adr_i = 6'h00;
   logic [3:0]  wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0]  lv = 4'h0;
   logic        se_req = 1'b0;
   logic [7:0]  rd_val;
   wire  [31:0] wb_dat_o;
   wire  [3:0]  compare_mode_field;
   wire         wb_ack_o, overflow_irq, gate_event_irq, gate_input_pin, period_match;
   wire         comparator_one, comparator_two, special_event, compare_uses_timer;
   int          errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   gate_timer i_gate_timer (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .gate_input_pin(gate_input_pin), .period_match(period_match),
      .comparator_one(comparator_one), .comparator_two(comparator_two),
      .external_clock_pin(1'b0), .crystal_osc_clock(1'b0), .special_event(special_event),
      .compare_mode_field(compare_mode_field), .compare_uses_timer(compare_uses_timer),
      .overflow_irq(overflow_irq), .gate_event_irq(gate_event_irq));
   gate_partner i_gate_partner (.clk_sys(clk_sys), .rst(rst), .lv(lv), .se_req(se_req),
      .gate_input_pin(gate_input_pin), .period_match(period_match),
      .comparator_one(comparator_one), .comparator_two(comparator_two),
      .special_event(special_event), .compare_mode_field(compare_mode_field),
      .compare_uses_timer(compare_uses_timer));
   // ==========================================================
   // Clock, timeout and common tasks
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         test_done;
      end
   end
   task test_done;
      $display("checked %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wb(input logic w, input logic [5:0] a, input logic [7:0] d, input logic se);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      se_req <= se;
      @(posedge clk_sys);
      se_req <= 1'b0;
      while (wb_ack_o !== 1'b1) @(posedge clk_sys);
      rd_val = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 1'b0);
   endtask
   task rdc(input logic [5:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00, 1'b0);
      chk({8'h00, rd_val}, {8'h00, e});
   endtask
   task set_cnt(input logic [15:0] v);
      wr(6'h04, v[15:8]);
      wr(6'h00, v[7:0]);
   endtask
   task cnt_chk(input logic [15:0] e);
      rdc(6'h00, e[7:0]);
      rdc(6'h04, e[15:8]);
   endtask
   task gate(input logic [3:0] l, input int n);
      @(posedge clk_sys);
      lv <= l;
      repeat (n) @(posedge clk_sys);
      lv <= 4'h0;
      repeat (6) @(posedge clk_sys);
   endtask
   // ==========================================================
   // Scenarios
   task test_reset;
      for (int i = 0; i < 7; i++) rdc(6'(4 * i), (i == 3) ? 8'h04 : 8'h00);
      wr(6'h18, 8'hFF);
      rdc(6'h18, 8'h00);
      $display("reset test done");
   endtask
   task test_overflow;
      wr(6'h14, 8'h03);
      wr(6'h08, 8'h41);
      wr(6'h0C, 8'hC0);
      set_cnt(16'hFFFE);
      gate(4'h1, 5);
      cnt_chk(16'h0003);
      rdc(6'h10, 8'h01);
      chk({15'h0000, overflow_irq}, 16'h0001);
      wr(6'h14, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk({15'h0000, overflow_irq}, 16'h0000);
      wr(6'h10, 8'h00);
      rdc(6'h10, 8'h00);
      $display("overflow test done");
   endtask
   task test_event;
      set_cnt(16'h1234);
      @(posedge clk_sys);
      se_req <= 1'b1;
      @(posedge clk_sys);
      se_req <= 1'b0;
      cnt_chk(16'h0000);
      rdc(6'h10, 8'h00);
      wb(1'b1, 6'h00, 8'h55, 1'b1);
      cnt_chk(16'h0055);
      wr(6'h08, 8'h43);
      wr(6'h04, 8'hA5);
      rdc(6'h04, 8'hA5);
      wr(6'h00, 8'h5A);
      wr(6'h08, 8'h41);
      cnt_chk(16'hA55A);
      $display("event test done");
   endtask
   task test_sources;
      for (int s = 0; s < 4; s++) begin
         wr(6'h0C, 8'hC0 | 8'(s));
         set_cnt(16'h0000);
         gate(4'(4'h1 << s), (s == 1) ? 40 : 10);
         cnt_chk((s == 1) ? 16'h0005 : 16'h000A);
      end
      @(posedge clk_sys);
      lv <= 4'h1;
      wr(6'h0C, 8'h80);
      set_cnt(16'h0100);
      cnt_chk(16'h0100);
      wr(6'h0C, 8'h40);
      rdc(6'h0C, 8'h44);
      lv <= 4'h0;
      wr(6'h08, 8'h01);
      wr(6'h0C, 8'hC0);
      set_cnt(16'h0000);
      gate(4'h1, 12);
      cnt_chk(16'h0003);
      wr(6'h08, 8'h41);
      $display("source test done");
   endtask
   task test_toggle;
      wr(6'h0C, 8'hE0);
      set_cnt(16'h0000);
      gate(4'h1, 3);
      gate(4'h1, 3);
      cnt_chk(16'h000A);
      gate(4'h1, 3);
      rdc(6'h0C, 8'hE4);
      wr(6'h0C, 8'hC0);
      wr(6'h0C, 8'hE0);
      set_cnt(16'h0100);
      cnt_chk(16'h0100);
      $display("toggle test done");
   endtask
   task test_single;
      wr(6'h14, 8'h02);
      for (int t = 0; t < 2; t++) begin
         wr(6'h0C, 8'hD0 | 8'(t << 5));
         set_cnt(16'h0000);
         wr(6'h0C, 8'hD8 | 8'(t << 5));
         gate(4'h1, 6);
         gate(4'h1, 6);
         cnt_chk((t == 1) ? 16'h000D : 16'h0006);
         rdc(6'h0C, 8'hD0 | 8'(t << 5));
         rdc(6'h10, 8'h02);
         chk({15'h0000, gate_event_irq}, 16'h0001);
         wr(6'h10, 8'h00);
      end
      gate(4'h1, 6);
      cnt_chk(16'h000D);
      wr(6'h14, 8'h00);
      wr(6'h0C, 8'hD8);
      wr(6'h0C, 8'hC8);
      rdc(6'h0C, 8'hC0);
      $display("single pulse test done");
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      test_reset;
      test_overflow;
      test_event;
      test_sources;
      test_toggle;
      test_single;
      test_done;
   end
endmodule
bind gate_timer gate_timer_props i_gate_timer_props (.clk_sys(clk_sys), .rst(rst),
   .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .overflow_irq(overflow_irq), .gate_event_irq(gate_event_irq));
